/* File: hdl/nic_descriptor_dma.sv */
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "nic_dma_defs.svh"
module nic_descriptor_dma
  import nic_dma_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  // register bus
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  // descriptor master port
  output logic                   MEM_REQ,
  output logic                   MEM_WE,
  output logic [31:0]            MEM_ADDR,
  output logic [31:0]            MEM_WDATA,
  input  wire logic              MEM_ACK,
  input  wire logic [31:0]       MEM_RDATA,
  // receive line and mac status
  input  wire logic [1:0]        RXD,
  input  wire logic              RX_DV,
  input  wire logic              RX_CRC_BAD,
  input  wire logic              RX_FIFO_OVF,
  output logic                   RX_BUF_VALID,
  output logic [31:0]            RX_BUF_ADDR,
  // transmit mac
  output logic                   TX_REQ,
  output tx_ctrl_t               TX_CTRL,
  output logic [31:0]            TX_BUF_ADDR,
  output logic [10:0]            TX_BUF_LEN,
  input  wire logic              TX_DONE,
  input  wire tx_stat_t          TX_STAT
);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  // ********************************************************
  // register bus slave
  // ********************************************************
  logic              aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q, rdata_q, rd_data;
  logic [3:0]        w_strb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic              wr_go, wr_hit, rd_hit;
  logic              wr_ctrl, wr_rxb, wr_txb, wr_sts, wr_cfg, rx_poll, tx_poll;
  logic [1:0]        ctrl_q;
  logic [31:0]       rx_base_q, tx_base_q;
  logic              csum_mode_q, tx_irq_q, jab_q, tx_irq_set, jab_set;
  rx_dma_t           rx_st_q;
  tx_dma_t           tx_st_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  assign AWREADY = !aw_have_q && !bvalid_q;
  assign WREADY  = !w_have_q && !bvalid_q;
  assign ARREADY = !rvalid_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign RVALID  = rvalid_q;
  assign RDATA   = rdata_q;
  assign RRESP   = rresp_q;
  assign wr_go   = aw_have_q && w_have_q && !bvalid_q;

  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_rxb  = 1'b0;
    wr_txb  = 1'b0;
    wr_sts  = 1'b0;
    wr_cfg  = 1'b0;
    rx_poll = 1'b0;
    tx_poll = 1'b0;
    wr_hit  = 1'b1;
    if (aw_addr_q == ADDR_W'(`OFS_CTRL))
      wr_ctrl = wr_go;
    else if (aw_addr_q == ADDR_W'(`OFS_RX_POLL))
      rx_poll = wr_go;
    else if (aw_addr_q == ADDR_W'(`OFS_TX_POLL))
      tx_poll = wr_go;
    else if (aw_addr_q == ADDR_W'(`OFS_RX_BASE))
      wr_rxb = wr_go;
    else if (aw_addr_q == ADDR_W'(`OFS_TX_BASE))
      wr_txb = wr_go;
    else if (aw_addr_q == ADDR_W'(`OFS_STS5))
      wr_sts = wr_go;
    else if (aw_addr_q == ADDR_W'(`OFS_CFG15))
      wr_cfg = wr_go;
    else
      wr_hit = 1'b0;
  end

  always_comb
  begin
    rd_data = `RST_WORD;
    rd_hit  = 1'b1;
    if (ARADDR == ADDR_W'(`OFS_CTRL))
      rd_data = {30'h0, ctrl_q};
    else if (ARADDR == ADDR_W'(`OFS_RX_POLL) || ARADDR == ADDR_W'(`OFS_TX_POLL))
      rd_data = `RST_WORD;
    else if (ARADDR == ADDR_W'(`OFS_RX_BASE))
      rd_data = rx_base_q;
    else if (ARADDR == ADDR_W'(`OFS_TX_BASE))
      rd_data = tx_base_q;
    else if (ARADDR == ADDR_W'(`OFS_STS5))
      rd_data = {21'h0, tx_st_q, 1'b0, rx_st_q, jab_q, 2'h0, tx_irq_q};
    else if (ARADDR == ADDR_W'(`OFS_CFG15))
      rd_data = {csum_mode_q, 31'h0};
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= `RST_WORD;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OK;
      rvalid_q  <= 1'b0;
      rdata_q   <= `RST_WORD;
      rresp_q   <= `RESP_OK;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_have_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `RESP_OK : `RESP_ERR;
      end
      else if (BREADY && bvalid_q)
        bvalid_q <= 1'b0;
      if (ARVALID && ARREADY)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_data;
        rresp_q  <= rd_hit ? `RESP_OK : `RESP_ERR;
      end
      else if (RREADY && rvalid_q)
        rvalid_q <= 1'b0;
    end
  end

  // sticky status: a set in the clearing cycle wins
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_q      <= 2'h0;
      rx_base_q   <= `RST_WORD;
      tx_base_q   <= `RST_WORD;
      csum_mode_q <= 1'b0;
      tx_irq_q    <= 1'b0;
      jab_q       <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && w_strb_q[0])
        ctrl_q <= w_data_q[1:0];
      if (wr_rxb)
        rx_base_q <= merge(rx_base_q, w_data_q, w_strb_q);
      if (wr_txb)
        tx_base_q <= merge(tx_base_q, w_data_q, w_strb_q);
      if (wr_cfg && w_strb_q[3])
        csum_mode_q <= w_data_q[`CFG_CSUM];
      tx_irq_q <= tx_irq_set || (tx_irq_q && !(wr_sts && w_strb_q[0] && w_data_q[`STS_TX_IRQ]));
      jab_q    <= jab_set || (jab_q && !(wr_sts && w_strb_q[0] && w_data_q[`STS_JAB]));
    end
  end

  // ********************************************************
  // receive line: preamble sync and frame length
  // ********************************************************
  logic [1:0]  rxd_s1_q, rxd_s2_q;
  logic        dv_s1_q, dv_s2_q;
  lin_t        lin_q;
  logic [7:0]  sh_q, sh_d;
  logic [2:0]  pre_q;
  logic [15:0] pairs_q;
  logic        odd_pair, frame_start, frame_end;

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rxd_s1_q <= 2'h0;
      rxd_s2_q <= 2'h0;
      dv_s1_q  <= 1'b0;
      dv_s2_q  <= 1'b0;
    end
    else
    begin
      rxd_s1_q <= RXD;
      rxd_s2_q <= rxd_s1_q;
      dv_s1_q  <= RX_DV;
      dv_s2_q  <= dv_s1_q;
    end
  end

  assign sh_d        = {sh_q[5:0], rxd_s2_q};
  assign odd_pair    = (rxd_s2_q == 2'h0) || (rxd_s2_q == 2'h3);
  assign frame_start = (lin_q == LIN_PRE) && dv_s2_q && (sh_d == `SFD_BYTE);
  assign frame_end   = (lin_q == LIN_DATA) && !dv_s2_q;

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      lin_q   <= LIN_IDLE;
      sh_q    <= 8'h0;
      pre_q   <= 3'h0;
      pairs_q <= 16'h0;
    end
    else
    begin
      case (lin_q)
        LIN_IDLE:
          if (dv_s2_q)
          begin
            lin_q <= LIN_PRE;
            sh_q  <= {6'h0, rxd_s2_q};
            pre_q <= 3'h1;
          end
        LIN_PRE:
          if (!dv_s2_q)
            lin_q <= LIN_IDLE;
          else if (sh_d == `SFD_BYTE)
          begin
            lin_q   <= LIN_DATA;
            pairs_q <= 16'h0;
          end
          else if (pre_q >= `PRE_PAIRS && odd_pair)
            lin_q <= LIN_DROP;
          else
          begin
            sh_q <= sh_d;
            if (pre_q < `PRE_PAIRS)
              pre_q <= pre_q + 3'h1;
          end
        LIN_DATA:
          if (!dv_s2_q)
            lin_q <= LIN_IDLE;
          else
            pairs_q <= pairs_q + 16'h1;
        default:
          if (!dv_s2_q)
            lin_q <= LIN_IDLE;
      endcase
    end
  end

  // ********************************************************
  // descriptor master engine
  // ********************************************************
  logic        mem_busy_q, mem_who_q, mem_we_q, mem_done_q;
  logic [1:0]  mem_idx_q;
  logic [31:0] mem_addr_q, rx_cur_q, tx_cur_q;
  logic [31:0] rx_desc_q [0:3];
  logic [31:0] tx_desc_q [0:3];
  logic        rx_need, tx_need, rx_mem_done, tx_mem_done;

  assign rx_need     = (rx_st_q == RX_FETCH) || (rx_st_q == RX_WB);
  assign tx_need     = (tx_st_q == TX_FETCH) || (tx_st_q == TX_WB);
  assign rx_mem_done = mem_done_q && !mem_who_q;
  assign tx_mem_done = mem_done_q && mem_who_q;
  assign MEM_REQ     = mem_busy_q;
  assign MEM_WE      = mem_we_q;
  assign MEM_ADDR    = mem_addr_q;
  assign MEM_WDATA   = mem_who_q ? tx_desc_q[mem_idx_q] : rx_desc_q[mem_idx_q];

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mem_busy_q <= 1'b0;
      mem_who_q  <= 1'b0;
      mem_we_q   <= 1'b0;
      mem_done_q <= 1'b0;
      mem_idx_q  <= 2'h0;
      mem_addr_q <= `RST_WORD;
    end
    else
    begin
      mem_done_q <= 1'b0;
      if (mem_busy_q)
      begin
        if (MEM_ACK)
        begin
          mem_addr_q <= mem_addr_q + 32'h4;
          mem_idx_q  <= mem_idx_q + 2'h1;
          if (mem_idx_q == 2'h3)
          begin
            mem_busy_q <= 1'b0;
            mem_we_q   <= 1'b0;
            mem_done_q <= 1'b1;
          end
        end
      end
      else if (!mem_done_q && (rx_need || tx_need))
      begin
        mem_busy_q <= 1'b1;
        mem_who_q  <= !rx_need;
        mem_we_q   <= rx_need ? (rx_st_q == RX_WB) : (tx_st_q == TX_WB);
        mem_idx_q  <= 2'h0;
        mem_addr_q <= rx_need ? rx_cur_q : tx_cur_q;
      end
    end
  end

  // ********************************************************
  // receive process
  // ********************************************************
  logic [31:0] rx_status;
  assign rx_status = {1'b0, 1'b0, pairs_q[15:2], (RX_CRC_BAD || RX_FIFO_OVF), 5'h0, 1'b1, 1'b1, 5'h0,
                      (pairs_q[1:0] != 2'h0), RX_CRC_BAD, RX_FIFO_OVF};
  assign RX_BUF_VALID = (rx_st_q == RX_READY);
  assign RX_BUF_ADDR  = rx_desc_q[2];

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_st_q  <= RX_STOP;
      rx_cur_q <= `RST_WORD;
      for (int i = 0; i < 4; i++)
        rx_desc_q[i] <= `RST_WORD;
    end
    else
    begin
      if (mem_busy_q && !mem_who_q && !mem_we_q && MEM_ACK)
        rx_desc_q[mem_idx_q] <= MEM_RDATA;
      case (rx_st_q)
        RX_STOP:
          if (ctrl_q[`CTRL_RX_RUN])
          begin
            rx_cur_q <= rx_base_q;
            rx_st_q  <= RX_FETCH;
          end
        RX_FETCH:
          if (rx_mem_done)
            rx_st_q <= rx_desc_q[0][`D_OWN] ? RX_READY : RX_SUSP;
        RX_READY:
          if (frame_end)
          begin
            rx_desc_q[0] <= rx_status;
            rx_st_q      <= RX_WB;
          end
          else if (!ctrl_q[`CTRL_RX_RUN])
            rx_st_q <= RX_STOP;
        RX_WB:
          if (rx_mem_done)
          begin
            rx_cur_q <= rx_desc_q[3];
            rx_st_q  <= ctrl_q[`CTRL_RX_RUN] ? RX_FETCH : RX_STOP;
          end
        default:
          if (!ctrl_q[`CTRL_RX_RUN])
            rx_st_q <= RX_STOP;
          else if (rx_poll || frame_start)
            rx_st_q <= RX_FETCH;
      endcase
    end
  end

  // ********************************************************
  // transmit process
  // ********************************************************
  logic [31:0] tx_status;
  logic        loss, nocar, late, excess, tx_err;
  assign loss   = TX_STAT.carrier_loss_flag && !TX_STAT.loopback;
  assign nocar  = TX_STAT.no_carrier && !TX_STAT.loopback;
  assign late   = TX_STAT.late_collision_flag && !TX_STAT.tx_underrun_flag;
  assign excess = TX_STAT.collisions >= `EXCESS_COLL;
  assign tx_err = TX_STAT.jabber_timeout_flag || loss || nocar || late || excess || TX_STAT.tx_underrun_flag;
  assign tx_status = {1'b0, 15'h0, tx_err, TX_STAT.jabber_timeout_flag, 2'h0, loss, nocar, late, excess, 1'b0,
                      (excess ? 4'h0 : TX_STAT.collisions[3:0]), 1'b0,
                      TX_STAT.tx_underrun_flag, TX_STAT.deferred_flag};
  assign tx_irq_set = (tx_st_q == TX_SEND) && TX_DONE && tx_desc_q[1][`TC_CI]
                      && (tx_desc_q[1][`TC_LAST] || tx_desc_q[1][`TC_SETUP]);
  assign jab_set    = (tx_st_q == TX_SEND) && TX_DONE && TX_STAT.jabber_timeout_flag;

  assign TX_REQ      = (tx_st_q == TX_SEND);
  assign TX_BUF_ADDR = tx_desc_q[2];
  assign TX_BUF_LEN  = tx_desc_q[1][10:0];
  assign TX_CTRL.first_segment_marker = tx_desc_q[1][`TC_FIRST];
  assign TX_CTRL.last_segment_marker  = tx_desc_q[1][`TC_LAST];
  assign TX_CTRL.setup_frame_marker   = tx_desc_q[1][`TC_SETUP];
  assign TX_CTRL.filter_type = tx_desc_q[1][`TC_SETUP] ? {tx_desc_q[1][`TC_FILTER_TYPE_HIGH], tx_desc_q[1][`TC_FILTER_TYPE_LOW]} : 2'h0;
  assign TX_CTRL.crc_append_off = tx_desc_q[1][`TC_CRC_OFF] && tx_desc_q[1][`TC_FIRST];
  assign TX_CTRL.pad_off  = tx_desc_q[1][`TC_PAD_OFF];
  assign TX_CTRL.ip_csum  = tx_desc_q[1][`TC_IP] && csum_mode_q;
  assign TX_CTRL.tcp_csum = tx_desc_q[1][`TC_TCP] && csum_mode_q;
  assign TX_CTRL.udp_csum = tx_desc_q[1][`TC_UDP] && csum_mode_q;

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tx_st_q  <= TX_STOP;
      tx_cur_q <= `RST_WORD;
      for (int i = 0; i < 4; i++)
        tx_desc_q[i] <= `RST_WORD;
    end
    else
    begin
      if (mem_busy_q && mem_who_q && !mem_we_q && MEM_ACK)
        tx_desc_q[mem_idx_q] <= MEM_RDATA;
      case (tx_st_q)
        TX_STOP:
          if (ctrl_q[`CTRL_TX_RUN])
          begin
            tx_cur_q <= tx_base_q;
            tx_st_q  <= TX_FETCH;
          end
        TX_FETCH:
          if (tx_mem_done)
            tx_st_q <= tx_desc_q[0][`D_OWN] ? TX_SEND : TX_SUSP;
        TX_SEND:
          if (TX_DONE)
          begin
            tx_desc_q[0] <= tx_status;
            tx_st_q      <= TX_WB;
          end
        TX_WB:
          if (tx_mem_done)
          begin
            tx_cur_q <= tx_desc_q[3];
            if (tx_desc_q[0][`TX_FUE] || tx_desc_q[0][`TX_JAB])
              tx_st_q <= TX_SUSP;
            else
              tx_st_q <= ctrl_q[`CTRL_TX_RUN] ? TX_FETCH : TX_STOP;
          end
        default:
          if (!ctrl_q[`CTRL_TX_RUN])
            tx_st_q <= TX_STOP;
          else if (tx_poll)
            tx_st_q <= TX_FETCH;
      endcase
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  a_rx_align_flag: assert property (
    frame_end && rx_st_q == RX_READY && pairs_q[1:0] != 2'h0 |=> rx_desc_q[0][`RX_ALIGN] && rx_st_q == RX_WB)
    else $error("alignment flag not stored");
  a_rx_crc_flag: assert property (
    frame_end && rx_st_q == RX_READY && RX_CRC_BAD |=> rx_desc_q[0][`RX_CRC] && rx_desc_q[0][`RX_ES])
    else $error("crc flag not stored");
  a_rx_own_release: assert property (
    rx_st_q == RX_WB |-> !rx_desc_q[0][`D_OWN])
    else $error("rx descriptor written back still owned");
  a_tx_own_release: assert property (
    tx_st_q == TX_WB && $past(tx_st_q) == TX_SEND |-> !tx_desc_q[0][`D_OWN])
    else $error("tx descriptor written back still owned");
  a_tx_error_summary: assert property (
    tx_st_q == TX_WB |-> tx_desc_q[0][`TX_ES] == (|{tx_desc_q[0][14], tx_desc_q[0][11:8], tx_desc_q[0][1]}))
    else $error("error summary mismatch");
  a_tx_jabber_status: assert property (
    tx_st_q == TX_SEND && TX_DONE && TX_STAT.jabber_timeout_flag |=> jab_q && tx_desc_q[0][`TX_JAB])
    else $error("jabber not reported");
  a_tx_coll_field: assert property (
    tx_st_q == TX_WB |-> !tx_desc_q[0][`TX_RSV7] && !tx_desc_q[0][`TX_RSV2]
                         && (!tx_desc_q[0][`TX_EC] || tx_desc_q[0][6:3] == 4'h0))
    else $error("collision field wrong");
  a_tx_done_irq: assert property (
    tx_st_q == TX_SEND && TX_DONE && tx_desc_q[1][`TC_CI] && tx_desc_q[1][`TC_LAST] |=> tx_irq_q)
    else $error("completion interrupt missing");
  a_tx_error_suspend: assert property (
    tx_st_q == TX_WB && tx_mem_done && tx_desc_q[0][`TX_FUE] |=> tx_st_q == TX_SUSP)
    else $error("no suspend after underrun");
  a_sfd_bad_pair: assert property (
    lin_q == LIN_PRE && dv_s2_q && sh_d != `SFD_BYTE && pre_q >= `PRE_PAIRS && odd_pair |=> lin_q == LIN_DROP)
    else $error("bad preamble pair not dropped");
  a_mem_write_owned: assert property (
    MEM_REQ && MEM_WE |-> (!mem_who_q && rx_st_q == RX_WB) || (mem_who_q && tx_st_q == TX_WB))
    else $error("descriptor write outside write-back");
  c_rx_frame_stored: cover property (rx_st_q == RX_WB && rx_mem_done);
  c_tx_frame_sent: cover property (tx_st_q == TX_WB && tx_mem_done);
  c_rx_suspended: cover property (rx_st_q == RX_SUSP ##1 rx_st_q == RX_FETCH);
  c_tx_suspended: cover property (tx_st_q == TX_SUSP);

endmodule

/* File: hdl/nic_dma_defs.svh */
`ifndef NIC_DMA_DEFS_SVH
`define NIC_DMA_DEFS_SVH
// register offsets
`define OFS_CTRL    8'h00
`define OFS_RX_POLL 8'h04
`define OFS_TX_POLL 8'h08
`define OFS_RX_BASE 8'h0c
`define OFS_TX_BASE 8'h10
`define OFS_STS5    8'h14
`define OFS_CFG15   8'h18
// register fields and reset values
`define CTRL_RX_RUN 0
`define CTRL_TX_RUN 1
`define STS_TX_IRQ  0
`define STS_JAB     3
`define CFG_CSUM    31
`define RST_WORD    32'h0000_0000
`define RESP_OK     2'h0
`define RESP_ERR    2'h2
// descriptor fields
`define D_OWN       31
`define RX_ES       15
`define RX_ALIGN    2
`define RX_CRC      1
`define RX_OVF      0
`define TX_ES       15
`define TX_JAB      14
`define TX_EC       8
`define TX_RSV7     7
`define TX_RSV2     2
`define TX_FUE      1
`define TC_CI       31
`define TC_LAST     30
`define TC_FIRST    29
`define TC_FILTER_TYPE_HIGH     28
`define TC_SETUP    27
`define TC_CRC_OFF  26
`define TC_PAD_OFF  23
`define TC_FILTER_TYPE_LOW     22
`define TC_IP       21
`define TC_TCP      20
`define TC_UDP      19
// line and collision figures
`define SFD_BYTE    8'hab
`define PRE_PAIRS   3'h4
`define EXCESS_COLL 5'h10
`endif

/* File: hdl/nic_dma_pkg.sv */
package nic_dma_pkg;
  typedef enum logic [2:0] {RX_STOP = 3'h0, RX_FETCH = 3'h1, RX_READY = 3'h2, RX_WB = 3'h3, RX_SUSP = 3'h4} rx_dma_t;
  typedef enum logic [2:0] {TX_STOP = 3'h0, TX_FETCH = 3'h1, TX_SEND = 3'h2, TX_WB = 3'h3, TX_SUSP = 3'h4} tx_dma_t;
  typedef enum logic [1:0] {LIN_IDLE = 2'h0, LIN_PRE = 2'h1, LIN_DATA = 2'h2, LIN_DROP = 2'h3} lin_t;
  typedef struct packed {
    logic       first_segment_marker;
    logic       last_segment_marker;
    logic       setup_frame_marker;
    logic [1:0] filter_type;
    logic       crc_append_off;
    logic       pad_off;
    logic       ip_csum;
    logic       tcp_csum;
    logic       udp_csum;
  } tx_ctrl_t;
  typedef struct packed {
    logic       jabber_timeout_flag;
    logic       carrier_loss_flag;
    logic       no_carrier;
    logic       late_collision_flag;
    logic [4:0] collisions;
    logic       tx_underrun_flag;
    logic       deferred_flag;
    logic       loopback;
  } tx_stat_t;
endpackage

/* File: verif/host_mem_model.sv */
`timescale 1ns/1ps
module host_mem_model
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // descriptor port
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  output logic             ack,
  output logic [31:0]      rdata
);
  logic [31:0] m [32];
  logic        ack_q;
  // acks every other cycle, so the first word of a burst is acked at once and each later word waits once
  assign ack = req && !ack_q;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      ack_q <= 1'b0;
    else
      ack_q <= ack;
  always @(posedge clk)
    if (ack && we)
      m[addr[6:2]] <= wdata;
  // released data bus shows the inverse word
  assign rdata = ack ? m[addr[6:2]] : ~m[addr[6:2]];
endmodule

/* File: verif/tb_nic_descriptor_dma.sv */
`timescale 1ns/1ps
`include "nic_dma_defs.svh"
module tb_nic_descriptor_dma;
  import nic_dma_pkg::*;
  logic        CORE_CLK = 0, RST_B = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic        RX_DV = 0, RX_CRC_BAD = 0, RX_FIFO_OVF = 0, TX_DONE = 0;
  logic [7:0]  AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0;
  logic [3:0]  WSTRB = 0;
  logic [1:0]  RXD = 0;
  tx_stat_t    TX_STAT = '0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, MEM_REQ, MEM_WE, MEM_ACK, RX_BUF_VALID, TX_REQ;
  logic [1:0]  BRESP, RRESP, rr;
  logic [31:0] RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, RX_BUF_ADDR, TX_BUF_ADDR, rv;
  logic [10:0] TX_BUF_LEN;
  tx_ctrl_t    TX_CTRL;
  int          fail_count = 0, tests_run = 0;
  always #20 CORE_CLK = ~CORE_CLK;
  nic_descriptor_dma DUT (.CORE_CLK, .RST_B, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .MEM_REQ,
    .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .MEM_RDATA, .RXD, .RX_DV, .RX_CRC_BAD, .RX_FIFO_OVF,
    .RX_BUF_VALID, .RX_BUF_ADDR, .TX_REQ, .TX_CTRL, .TX_BUF_ADDR, .TX_BUF_LEN, .TX_DONE, .TX_STAT);
  host_mem_model hm (.clk(CORE_CLK), .rst_b(RST_B), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    AWADDR <= a; WDATA <= d; WSTRB <= 4'hf; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    while (!(aw_done && w_done))
    begin
      @(posedge CORE_CLK);
      if (AWREADY) aw_done = 1;
      if (WREADY) w_done = 1;
      if (aw_done) AWVALID <= 0;
      if (w_done) WVALID <= 0;
    end
    while (BVALID !== 1'b1) @(posedge CORE_CLK);
    chk("write resp", `RESP_OK, BRESP);
    BREADY <= 0;
    @(posedge CORE_CLK);
  endtask
  task rd(input logic [7:0] a);
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    do @(posedge CORE_CLK); while (ARREADY !== 1'b1);
    ARVALID <= 0;
    do @(posedge CORE_CLK); while (RVALID !== 1'b1);
    rv = RDATA; rr = RRESP; RREADY <= 0;
    @(posedge CORE_CLK);
  endtask
  // poll a process state field of the status register
  task wait_state(input int sh);
    do rd(`OFS_STS5); while (rv[sh+:3] !== 3'h4);
  endtask
  task send(input logic [1:0] p);
    RXD <= p;
    @(posedge CORE_CLK);
  endtask
  task reset_test;
    rd(`OFS_STS5); chk("status", 32'h0, rv);
    rd(8'h40); chk("unmapped resp", 2'h2, rr);
    chk("unmapped data", 32'h0, rv);
    $display("reset test done");
  endtask
  task tx_test;
    wr(`OFS_TX_BASE, 32'h10); wr(`OFS_CTRL, 32'h2);
    while (TX_REQ !== 1'b1) @(posedge CORE_CLK);
    chk("tx ctrl", 10'h318, TX_CTRL);
    wr(`OFS_CFG15, 32'h8000_0000);
    chk("tx ctrl csum", 10'h31c, TX_CTRL);
    chk("tx len", 11'h040, TX_BUF_LEN);
    chk("tx addr", 32'h100, TX_BUF_ADDR);
    TX_STAT <= '{collisions: 5'h10, deferred_flag: 1'b1, default: '0}; TX_DONE <= 1;
    @(posedge CORE_CLK);
    TX_DONE <= 0;
    wait_state(8);
    chk("tx status word", 32'h0000_8101, hm.m[4]);
    chk("status", 32'h0000_0401, rv);
    $display("tx test done");
  endtask
  task tx_err_test;
    wr(`OFS_STS5, 32'h1);
    rd(`OFS_STS5);
    chk("irq cleared", 32'h0000_0400, rv);
    hm.m[16] = 32'h8000_0000;
    hm.m[17] = 32'h9d58_00c0;
    hm.m[18] = 32'h300;
    hm.m[19] = 32'h20;
    wr(`OFS_TX_POLL, 32'h0);
    while (TX_REQ !== 1'b1) @(posedge CORE_CLK);
    chk("setup ctrl", 10'h0e3, TX_CTRL);
    chk("setup addr", 32'h300, TX_BUF_ADDR);
    TX_STAT <= '{jabber_timeout_flag: 1'b1, carrier_loss_flag: 1'b1, no_carrier: 1'b1, late_collision_flag: 1'b1,
                 collisions: 5'h3, tx_underrun_flag: 1'b1, loopback: 1'b1, default: '0};
    TX_DONE <= 1;
    @(posedge CORE_CLK);
    TX_DONE <= 0;
    TX_STAT <= '0;
    wait_state(8);
    chk("error status word", 32'h0000_c01a, hm.m[16]);
    chk("error status", 32'h0000_0409, rv);
    $display("tx error test done");
  endtask
  task rx_test;
    wr(`OFS_RX_BASE, 32'h0); wr(`OFS_CTRL, 32'h3);
    while (RX_BUF_VALID !== 1'b1) @(posedge CORE_CLK);
    chk("rx buf addr", 32'h200, RX_BUF_ADDR);
    // bad pair after preamble, then a late delimiter that must be ignored
    RX_DV <= 1;
    repeat (5) send(2'b10);
    send(2'b00);
    repeat (3) send(2'b10);
    send(2'b11);
    send(2'b01);
    RX_DV <= 0;
    repeat (4) @(posedge CORE_CLK);
    chk("rx after bad pair", 32'h1, RX_BUF_VALID);
    RX_DV <= 1;
    repeat (6) send(2'b10);
    send(2'b11);
    repeat (5) send(2'b01);
    RX_DV <= 0; RX_CRC_BAD <= 1; RX_FIFO_OVF <= 1;
    repeat (6) @(posedge CORE_CLK);
    RX_CRC_BAD <= 0; RX_FIFO_OVF <= 0;
    wait_state(4);
    chk("rx status word", 32'h0001_8307, hm.m[0]);
    $display("rx test done");
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    // one dma-owned descriptor per list, chain bit set, aligned pointers
    hm.m[0] = 32'h8000_0000; hm.m[1] = 32'h0100_0600; hm.m[2] = 32'h200; hm.m[3] = 32'h20;
    hm.m[4] = 32'h8000_0000; hm.m[5] = 32'he5a0_0040; hm.m[6] = 32'h100; hm.m[7] = 32'h40;
    hm.m[8] = 32'h0; hm.m[16] = 32'h0;
    repeat (16) @(posedge CORE_CLK);
    RST_B <= 1;
    @(posedge CORE_CLK);
    reset_test;
    tx_test;
    tx_err_test;
    rx_test;
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    fail_count++;
    stop_test;
  end
endmodule
